// ### crg_pkg.sv
// crg_pkg: constants, register map and types of the clock and reset unit
package crg_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int NGRP = 11;        // clock groups
  localparam int FPG = 4;          // functions per group
  localparam int NFUNC = 44;       // NGRP * FPG
  localparam int NFDIV = 9;        // 3 single + 3 groups of 2
  localparam int NSRC = 8;         // selectable base sources
  localparam int NBLK = 32;        // blocks with a software reset
  localparam int NDSEL = 12;       // functions in the multi-divider groups

  // ----------------------------------------------------------------------
  // source codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] SRC_OSC = 3'h0;
  localparam logic [2:0] SRC_RTC = 3'h1;
  localparam logic [2:0] SRC_BCLK = 3'h2;
  localparam logic [2:0] SRC_WSEL = 3'h3;
  localparam logic [2:0] SRC_MCI = 3'h4;
  localparam logic [2:0] SRC_LPPLL = 3'h5;
  localparam logic [2:0] SRC_HSPLL = 3'h6;
  localparam logic [2:0] SRC_SYS = 3'h7;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_LPPLL = 12'h000;
  localparam logic [11:0] OFS_HSPLL = 12'h004;
  localparam logic [11:0] OFS_WDSTAT = 12'h008;
  localparam logic [11:0] OFS_GRPSEL = 12'h010;  // + 4 * group
  localparam logic [11:0] OFS_FDIV = 12'h040;    // + 4 * divider
  localparam logic [11:0] OFS_FNEN_LO = 12'h080;
  localparam logic [11:0] OFS_FNEN_HI = 12'h084;
  localparam logic [11:0] OFS_FNAUTO_LO = 12'h088;
  localparam logic [11:0] OFS_FNAUTO_HI = 12'h08C;
  localparam logic [11:0] OFS_DIVSEL = 12'h090;
  localparam logic [11:0] OFS_SOFTRST = 12'h0A0;
  localparam logic [11:0] OFS_GRPSTAT = 12'h0B0;
  localparam logic [11:0] OFS_FNON_LO = 12'h0B4;
  localparam logic [11:0] OFS_FNON_HI = 12'h0B8;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int FD_DEN_POS = 16;
  localparam int GS_ACT_POS = 4;
  localparam int GS_SW_POS = 8;
  localparam logic [11:0] FD_NUM_RST = 12'h001;
  localparam logic [11:0] FD_DEN_RST = 12'h001;
  localparam logic [NFUNC-1:0] FNEN_RST = {NFUNC{1'b1}};
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------------
  // pll configuration carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] refSel;    // [10:8]
    logic rsvd;            // [7]
    logic [1:0] postSel;   // [6:5] divide by 1, 2, 4, 8
    logic [4:0] multM1;    // [4:0] multiply minus one
  } crg_lp_cfg_t;

  typedef struct packed {
    logic [2:0] refSel;    // [26:24]
    logic [1:0] rsvd;
    logic [3:0] postM1;    // [21:18]
    logic [9:0] multM1;    // [17:8]
    logic [7:0] preM1;     // [7:0]
  } crg_hs_cfg_t;

  localparam crg_lp_cfg_t LP_CFG_RST = '0;
  localparam crg_hs_cfg_t HS_CFG_RST = '0;

endpackage : crg_pkg

// ### crg_rate_scaler.sv
// crg_rate_scaler: pre-divide, multiply and post-divide of a tick stream
`timescale 1ns/1ps
`default_nettype none
module crg_rate_scaler (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // reference and ratio
  input wire logic refTick,
  input wire logic [7:0] preM1,
  input wire logic [9:0] multM1,
  input wire logic [3:0] postM1,
  // generated tick
  output logic outTick
);

  logic [7:0] preCnt_q;
  logic [11:0] credit_q;
  logic [11:0] credit_d;
  logic preTick;
  logic emit;

  // -----------------------------------------------------------------------
  // pre-divider and credit bookkeeping
  // -----------------------------------------------------------------------
  assign preTick = refTick && (preCnt_q == preM1);
  assign emit = credit_q >= ({8'h00, postM1} + 12'h001);

  // credit saturates so a runaway reference cannot wrap the counter
  always_comb
  begin
    credit_d = credit_q;
    if (emit)
      credit_d = credit_d - ({8'h00, postM1} + 12'h001);
    if (preTick && !credit_q[11])
      credit_d = credit_d + ({2'h0, multM1} + 12'h001);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      preCnt_q <= '0;
    else if (refTick)
      preCnt_q <= preTick ? 8'h00 : preCnt_q + 8'h01;
  end

  // output pulses carry multiply/divide credit
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      credit_q <= '0;
      outTick <= 1'b0;
    end
    else
    begin
      credit_q <= credit_d;
      outTick <= emit;
    end
  end

endmodule : crg_rate_scaler
`default_nettype wire

// ### crg_unit.sv
// crg_unit: clock source selection, division, gating and reset control
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module crg_unit (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // asynchronous clock reference pins
  input wire logic oscClkPin,
  input wire logic rtcClkPin,
  input wire logic i2sBitClkPin,
  input wire logic i2sWordSelPin,
  input wire logic mciClkPin,
  // reset sources
  input wire logic extRstN,
  input wire logic wdogRst,
  // event router clock requests
  input wire logic [crg_pkg::NFUNC-1:0] evtClkReq,
  // function clocks and resets
  output logic [crg_pkg::NFUNC-1:0] funcClkTick,
  output logic [crg_pkg::NFUNC-1:0] funcClkOn,
  output logic [crg_pkg::NBLK-1:0] blkRst,
  output logic chipRst,
  output logic [31:0] resetVector
);

  localparam int NG = crg_pkg::NGRP;
  localparam int NF = crg_pkg::NFUNC;
  localparam int ND = crg_pkg::NFDIV;

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  // group that feeds a fractional divider
  function automatic int divGroup(input int d);
    divGroup = (d < 3) ? d : 3 + (d - 3) / 2;
  endfunction : divGroup

  // one accumulator step: {tick, next accumulator}
  function automatic logic [12:0] fracNext(input logic [11:0] acc,
    input logic [11:0] num, input logic [11:0] den);
    logic [12:0] sum;
    sum = {1'b0, acc} + {1'b0, num};
    if (sum >= {1'b0, den})
      fracNext = {1'b1, 12'(sum - {1'b0, den})};
    else
      fracNext = {1'b0, sum[11:0]};
  endfunction : fracNext

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] dat, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        merge[i*8 +: 8] = dat[i*8 +: 8];
  endfunction : merge

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  logic [4:0] pinS1_q, pinS2_q, pinS3_q;
  logic rstS1_q, rstS2_q;
  logic chipRst_q, localRst, wdFlag_q;
  crg_pkg::crg_lp_cfg_t lpCfg_q;
  crg_pkg::crg_hs_cfg_t hsCfg_q;
  logic [2:0] grpSel_q [NG];
  logic [2:0] grpAct_q [NG];
  logic [NG-1:0] grpOn_q, grpTick;
  logic [11:0] fdNum_q [ND];
  logic [11:0] fdDen_q [ND];
  logic [11:0] fdAcc_q [ND];
  logic [ND-1:0] fdTick_q;
  logic [NF-1:0] fnEn_q, fnAuto_q, gate_q, fnSrc;
  logic [crg_pkg::NDSEL-1:0] divSel_q;
  logic [crg_pkg::NBLK-1:0] softRst_q;
  logic [crg_pkg::NSRC-1:0] srcTick;
  logic lpTick, hsTick, lpRef, hsRef;
  logic [11:0] awAddr_q, wrAddr, rdAddr;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic awHeld_q, wHeld_q, doWrite;
  logic [31:0] wrOld, wrVal, rdVal;
  logic wrHit, rdHit;

  // -----------------------------------------------------------------------
  // pin synchronisers and reset
  // -----------------------------------------------------------------------
  // two flops, a third only for rising-edge detection
  always_ff @(posedge mclk)
  begin
    pinS1_q <= {mciClkPin, i2sWordSelPin, i2sBitClkPin, rtcClkPin, oscClkPin};
    pinS2_q <= pinS1_q;
    pinS3_q <= pinS2_q;
    rstS1_q <= extRstN;
    rstS2_q <= rstS1_q;
  end

  // chip reset held for as long as either source asserts
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      chipRst_q <= 1'b1;
    else
      chipRst_q <= !rstS2_q || wdogRst;
  end

  // every control register below starts again from its reset value
  assign localRst = sys_rst || chipRst_q;
  assign chipRst = chipRst_q;

  // fetch address after release; fixed so boot code has one entry point
  always_ff @(posedge mclk)
  begin
    resetVector <= crg_pkg::RESET_VECTOR;
  end

  // watchdog cause survives its own reset; pin reset or power-up clears it
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !rstS2_q)
      wdFlag_q <= 1'b0;
    else if (wdogRst)
      wdFlag_q <= 1'b1;
    else if (doWrite && wrAddr == crg_pkg::OFS_WDSTAT && wData_q[0]
             && wStrb_q[0])
      wdFlag_q <= 1'b0;
  end

  // -----------------------------------------------------------------------
  // sources and plls
  // -----------------------------------------------------------------------
  assign srcTick = {1'b1, hsTick, lpTick, pinS2_q & ~pinS3_q};
  assign lpRef = srcTick[lpCfg_q.refSel];
  assign hsRef = srcTick[hsCfg_q.refSel];

  crg_rate_scaler lpPll (
    .mclk(mclk),
    .rst(localRst),
    .refTick(lpRef),
    .preM1(8'h00),
    .multM1({5'h00, lpCfg_q.multM1}),
    .postM1(4'((4'h1 << lpCfg_q.postSel) - 4'h1)),
    .outTick(lpTick)
  );

  crg_rate_scaler hsPll (
    .mclk(mclk),
    .rst(localRst),
    .refTick(hsRef),
    .preM1(hsCfg_q.preM1),
    .multM1(hsCfg_q.multM1),
    .postM1(hsCfg_q.postM1),
    .outTick(hsTick)
  );

  // -----------------------------------------------------------------------
  // groups, dividers and function gates
  // -----------------------------------------------------------------------
  for (genvar g = 0; g < NG; g++)
  begin : grp
    // drop the old source right after one of its whole pulses, idle a
    // cycle, then take the new one; a stopped old source stalls the change
    always_ff @(posedge mclk)
    begin
      if (localRst)
      begin
        grpAct_q[g] <= crg_pkg::SRC_OSC;
        grpOn_q[g] <= 1'b1;
      end
      else if (grpOn_q[g] && grpSel_q[g] != grpAct_q[g]
               && srcTick[grpAct_q[g]])
        grpOn_q[g] <= 1'b0;
      else if (!grpOn_q[g])
      begin
        grpAct_q[g] <= grpSel_q[g];
        grpOn_q[g] <= 1'b1;
      end
    end
    assign grpTick[g] = grpOn_q[g] && srcTick[grpAct_q[g]];
  end

  for (genvar d = 0; d < ND; d++)
  begin : fdiv
    // rate = group rate * num / den, whole pulses only
    always_ff @(posedge mclk)
    begin
      if (localRst)
      begin
        fdAcc_q[d] <= '0;
        fdTick_q[d] <= 1'b0;
      end
      else if (grpTick[divGroup(d)])
        {fdTick_q[d], fdAcc_q[d]} <=
          fracNext(fdAcc_q[d], fdNum_q[d], fdDen_q[d]);
      else
        fdTick_q[d] <= 1'b0;
    end
  end

  for (genvar f = 0; f < NF; f++)
  begin : fn
    localparam int G = f / crg_pkg::FPG;
    if (G < 3)
    begin : single
      assign fnSrc[f] = fdTick_q[G];
    end
    else if (G < 6)
    begin : multi
      assign fnSrc[f] = fdTick_q[3 + 2 * (G - 3) + int'(divSel_q[f - 12])];
    end
    else
    begin : plain
      assign fnSrc[f] = grpTick[G];
    end

    // gate moves every cycle, so a pulse is passed whole or not at all
    always_ff @(posedge mclk)
    begin
      if (localRst)
      begin
        gate_q[f] <= 1'b0;
        funcClkTick[f] <= 1'b0;
      end
      else
      begin
        gate_q[f] <= fnAuto_q[f] ? evtClkReq[f] : fnEn_q[f];
        funcClkTick[f] <= fnSrc[f] && gate_q[f];
      end
    end
  end

  assign funcClkOn = gate_q;

  // software reset bits, overridden by a chip reset
  assign blkRst = softRst_q | {crg_pkg::NBLK{chipRst_q}};

  // -----------------------------------------------------------------------
  // axi4-lite write channel
  // -----------------------------------------------------------------------
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign wrAddr = {awAddr_q[11:2], 2'h0};

  // address and data held in either order; response follows both
  always_ff @(posedge mclk)
  begin
    if (localRst)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= crg_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? crg_pkg::RESP_OKAY : crg_pkg::RESP_DECERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // shared decode: current contents of a writable word
  always_comb
  begin
    wrHit = 1'b1;
    wrOld = '0;
    if (wrAddr == crg_pkg::OFS_LPPLL)
      wrOld = 32'(lpCfg_q);
    else if (wrAddr == crg_pkg::OFS_HSPLL)
      wrOld = 32'(hsCfg_q);
    else if (wrAddr == crg_pkg::OFS_WDSTAT)
      wrOld = 32'h0000_0000;
    else if (wrAddr >= crg_pkg::OFS_GRPSEL && wrAddr < 12'h03C)
      wrOld = {29'h0, grpSel_q[wrAddr[5:2] - 4'h4]};
    else if (wrAddr >= crg_pkg::OFS_FDIV && wrAddr < 12'h064)
      wrOld = {4'h0, fdDen_q[wrAddr[5:2]], 4'h0, fdNum_q[wrAddr[5:2]]};
    else if (wrAddr == crg_pkg::OFS_FNEN_LO)
      wrOld = fnEn_q[31:0];
    else if (wrAddr == crg_pkg::OFS_FNEN_HI)
      wrOld = {20'h0, fnEn_q[NF-1:32]};
    else if (wrAddr == crg_pkg::OFS_FNAUTO_LO)
      wrOld = fnAuto_q[31:0];
    else if (wrAddr == crg_pkg::OFS_FNAUTO_HI)
      wrOld = {20'h0, fnAuto_q[NF-1:32]};
    else if (wrAddr == crg_pkg::OFS_DIVSEL)
      wrOld = {20'h0, divSel_q};
    else if (wrAddr == crg_pkg::OFS_SOFTRST)
      wrOld = softRst_q;
    else
      wrHit = 1'b0;
    wrVal = merge(wrOld, wData_q, wStrb_q);
  end

  // configuration registers
  always_ff @(posedge mclk)
  begin
    if (localRst)
    begin
      lpCfg_q <= crg_pkg::LP_CFG_RST;
      hsCfg_q <= crg_pkg::HS_CFG_RST;
      fnEn_q <= crg_pkg::FNEN_RST;
      fnAuto_q <= '0;
      divSel_q <= '0;
      softRst_q <= '0;
      for (int i = 0; i < NG; i++)
        grpSel_q[i] <= crg_pkg::SRC_OSC;
      for (int i = 0; i < ND; i++)
      begin
        fdNum_q[i] <= crg_pkg::FD_NUM_RST;
        fdDen_q[i] <= crg_pkg::FD_DEN_RST;
      end
    end
    else if (doWrite && wrHit)
    begin
      if (wrAddr == crg_pkg::OFS_LPPLL)
        lpCfg_q <= crg_pkg::crg_lp_cfg_t'(wrVal[10:0]);
      else if (wrAddr == crg_pkg::OFS_HSPLL)
        hsCfg_q <= crg_pkg::crg_hs_cfg_t'(wrVal[26:0]);
      else if (wrAddr >= crg_pkg::OFS_GRPSEL && wrAddr < 12'h03C)
        grpSel_q[wrAddr[5:2] - 4'h4] <= wrVal[2:0];
      else if (wrAddr >= crg_pkg::OFS_FDIV && wrAddr < 12'h064)
      begin
        fdNum_q[wrAddr[5:2]] <= wrVal[11:0];
        fdDen_q[wrAddr[5:2]] <= wrVal[crg_pkg::FD_DEN_POS +: 12];
      end
      else if (wrAddr == crg_pkg::OFS_FNEN_LO)
        fnEn_q[31:0] <= wrVal;
      else if (wrAddr == crg_pkg::OFS_FNEN_HI)
        fnEn_q[NF-1:32] <= wrVal[NF-33:0];
      else if (wrAddr == crg_pkg::OFS_FNAUTO_LO)
        fnAuto_q[31:0] <= wrVal;
      else if (wrAddr == crg_pkg::OFS_FNAUTO_HI)
        fnAuto_q[NF-1:32] <= wrVal[NF-33:0];
      else if (wrAddr == crg_pkg::OFS_DIVSEL)
        divSel_q <= wrVal[crg_pkg::NDSEL-1:0];
      else if (wrAddr == crg_pkg::OFS_SOFTRST)
        softRst_q <= wrVal;
    end
  end

  // -----------------------------------------------------------------------
  // axi4-lite read channel
  // -----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rdAddr = {s_axi_araddr[11:2], 2'h0};

  always_comb
  begin
    rdHit = 1'b1;
    rdVal = '0;
    if (rdAddr == crg_pkg::OFS_LPPLL)
      rdVal = 32'(lpCfg_q);
    else if (rdAddr == crg_pkg::OFS_HSPLL)
      rdVal = 32'(hsCfg_q);
    else if (rdAddr == crg_pkg::OFS_WDSTAT)
      rdVal = {31'h0, wdFlag_q};
    else if (rdAddr >= crg_pkg::OFS_GRPSEL && rdAddr < 12'h03C)
      rdVal = {23'h0, !grpOn_q[rdAddr[5:2] - 4'h4], 1'b0,
               grpAct_q[rdAddr[5:2] - 4'h4], 1'b0,
               grpSel_q[rdAddr[5:2] - 4'h4]};
    else if (rdAddr >= crg_pkg::OFS_FDIV && rdAddr < 12'h064)
      rdVal = {4'h0, fdDen_q[rdAddr[5:2]], 4'h0, fdNum_q[rdAddr[5:2]]};
    else if (rdAddr == crg_pkg::OFS_FNEN_LO)
      rdVal = fnEn_q[31:0];
    else if (rdAddr == crg_pkg::OFS_FNEN_HI)
      rdVal = {20'h0, fnEn_q[NF-1:32]};
    else if (rdAddr == crg_pkg::OFS_FNAUTO_LO)
      rdVal = fnAuto_q[31:0];
    else if (rdAddr == crg_pkg::OFS_FNAUTO_HI)
      rdVal = {20'h0, fnAuto_q[NF-1:32]};
    else if (rdAddr == crg_pkg::OFS_DIVSEL)
      rdVal = {20'h0, divSel_q};
    else if (rdAddr == crg_pkg::OFS_SOFTRST)
      rdVal = softRst_q;
    else if (rdAddr == crg_pkg::OFS_GRPSTAT)
      rdVal = {21'h0, grpOn_q};
    else if (rdAddr == crg_pkg::OFS_FNON_LO)
      rdVal = gate_q[31:0];
    else if (rdAddr == crg_pkg::OFS_FNON_HI)
      rdVal = {20'h0, gate_q[NF-1:32]};
    else
      rdHit = 1'b0;
  end

  // one-cycle read answer, held until taken
  always_ff @(posedge mclk)
  begin
    if (localRst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= crg_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdVal;
      s_axi_rresp <= rdHit ? crg_pkg::RESP_OKAY : crg_pkg::RESP_DECERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : crg_unit
`default_nettype wire

// ### crg_unit_sva.sv
// crg_unit_sva: port-level assertions of the clock and reset unit
`timescale 1ns/1ps
`default_nettype none
module crg_unit_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // reset sources and results
  input wire logic extRstN,
  input wire logic wdogRst,
  input wire logic chipRst,
  input wire logic [31:0] resetVector,
  input wire logic [crg_pkg::NBLK-1:0] blkRst,
  // function clocks
  input wire logic [crg_pkg::NFUNC-1:0] funcClkTick,
  input wire logic [crg_pkg::NFUNC-1:0] funcClkOn,
  // read channel
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // reset behaviour
  // ----------------------------------------
  vector_zero_a: assert property (resetVector == crg_pkg::RESET_VECTOR)
    else $error("reset vector not zero");
  wdog_reset_a: assert property (wdogRst |=> chipRst)
    else $error("watchdog did not reset the chip");
  pin_reset_a: assert property (!extRstN [*4] |=> chipRst)
    else $error("reset pin did not reset the chip");
  // two cycles allow for the registered function gates; block reset follows chipRst at once
  blk_hold_a: assert property (chipRst [*2] |-> &blkRst)
    else $error("block reset not held in chip reset");
  reset_quiet_a: assert property (chipRst [*2] |-> funcClkOn == '0)
    else $error("function gate open in chip reset");
  // ----------------------------------------
  // function clocks and bus
  // ----------------------------------------
  tick_gated_a: assert property ((funcClkTick & ~$past(funcClkOn)) == '0)
    else $error("tick on a closed gate");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready && !chipRst
    && !wdogRst |=> s_axi_rvalid)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  cover property (wdogRst);
  cover property ($fell(funcClkOn[0]));
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule : crg_unit_sva
`default_nettype wire

// ### clock_reset_generation_unit_bench.sv
// clock_reset_generation_unit_bench: self-checking bench of crg_unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("Error %s exp %0h got %0h", n, e, g); end end
module clock_reset_generation_unit_bench;
  logic mclk = 1'h0, sys_rst = 1'h1, extRstN = 1'h0, wdogRst = 1'h0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, resetVector, rd;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h1;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, chipRst;
  logic [1:0] bresp, rresp, rs, oscDiv = 2'h0;
  logic [crg_pkg::NFUNC-1:0] evtReq = '0, tick, on;
  logic [crg_pkg::NBLK-1:0] blkRst;
  int fails = 0, tests_run = 0;
  // ----------------------------------------
  // clocks and design
  // ----------------------------------------
  always #12.5 mclk = ~mclk;
  // oscillator pin at a quarter of mclk, slow enough to be seen
  always @(posedge mclk) oscDiv <= oscDiv + 2'h1;
  crg_unit DUT (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .oscClkPin(oscDiv[1]), .rtcClkPin(1'h0),
    .i2sBitClkPin(1'h0), .i2sWordSelPin(1'h0), .mciClkPin(1'h0),
    .extRstN(extRstN), .wdogRst(wdogRst), .evtClkReq(evtReq),
    .funcClkTick(tick), .funcClkOn(on), .blkRst(blkRst), .chipRst(chipRst),
    .resetVector(resetVector));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // ticks of one function clock over n cycles
  task automatic count_ticks(input int f, input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(posedge mclk);
      c += tick[f];
    end
  endtask : count_ticks
  task automatic tmo(input int n);
    if (n >= 40)
    begin
      fails++;
      conclude();
    end
  endtask : tmo
  // bready stays high for good, so no two drivers meet at one edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    rs = bresp;
    tmo(n);
  endtask : wr
  // rready rises only once rvalid is seen, so every read stalls a cycle
  task automatic rdr(input logic [11:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'h1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'h1;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
    tmo(n);
  endtask : rdr
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    `CHK("vector", 32'h0, resetVector)
    rdr(crg_pkg::OFS_FNEN_LO);
    `CHK("enables", 32'hFFFFFFFF, rd)
    wr(crg_pkg::OFS_LPPLL, 32'h0000061F);
    rdr(crg_pkg::OFS_LPPLL);
    `CHK("lp pll", 32'h0000061F, rd)
    wr(crg_pkg::OFS_HSPLL, 32'h053FFFFF);
    rdr(crg_pkg::OFS_HSPLL);
    `CHK("hs pll", 32'h053FFFFF, rd)
    rdr(12'hFFC);
    `CHK("bad rd", crg_pkg::RESP_DECERR, rs)
    wr(12'hFFC, 32'h1);
    `CHK("bad wr", crg_pkg::RESP_DECERR, rs)
  endtask : t_regs
  task automatic t_gate;
    int n, c;
    c = 0;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      c += tick[1];
    end
    `CHK("osc ticks", 1'h1, c >= 4)
    wr(crg_pkg::OFS_FNEN_LO, 32'hFFFFFFFE);
    cyc(3);
    `CHK("gate off", 2'h2, on[1:0])
    wr(crg_pkg::OFS_FNAUTO_LO, 32'h1);
    evtReq[0] <= 1'h1;
    cyc(3);
    `CHK("event on", 1'h1, on[0])
    evtReq[0] <= 1'h0;
    cyc(3);
    `CHK("event off", 1'h0, on[0])
  endtask : t_gate
  task automatic t_switch;
    int n, c;
    wr(crg_pkg::OFS_GRPSEL, 32'h7);
    for (n = 0; n < 40; n++)
    begin
      rdr(crg_pkg::OFS_GRPSEL);
      if (rd[6:4] == 3'h7) break;
    end
    `CHK("group", 32'h77, rd)
    cyc(2);
    `CHK("sys tick", 1'h1, tick[1])
    wr(crg_pkg::OFS_FDIV, 32'h00020001);
    cyc(3);
    c = 0;
    for (n = 0; n < 8; n++)
    begin
      @(posedge mclk);
      c += tick[1];
    end
    `CHK("half rate", 4, c)
  endtask : t_switch
  // group 3 dividers at 1/1 and 1/2; function 12 picks the second
  task automatic t_multi;
    int c;
    wr(crg_pkg::OFS_FDIV + 12'h010, 32'h00020001);
    wr(crg_pkg::OFS_DIVSEL, 32'h1);
    cyc(4);
    count_ticks(13, 32, c);
    `CHK("pair first", 8, c)
    count_ticks(12, 32, c);
    `CHK("pair second", 4, c)
  endtask : t_multi
  // run after a chip reset so no pll credit is left over
  task automatic t_pll;
    int c;
    wr(crg_pkg::OFS_LPPLL, 32'h00000001);
    wr(crg_pkg::OFS_GRPSEL + 12'h018, 32'h5);
    cyc(12);
    count_ticks(24, 32, c);
    `CHK("lp pll rate", 16, c)
  endtask : t_pll
  task automatic t_resets;
    wr(crg_pkg::OFS_SOFTRST, 32'h1);
    `CHK("soft rst", 2'h1, blkRst[1:0])
    wdogRst <= 1'h1;
    @(posedge mclk);
    wdogRst <= 1'h0;
    @(posedge mclk);
    `CHK("wdog chip", 1'h1, chipRst)
    cyc(3);
    `CHK("blk clear", 32'h0, blkRst)
    rdr(crg_pkg::OFS_WDSTAT);
    `CHK("wd flag", 32'h1, rd)
    extRstN <= 1'h0;
    cyc(4);
    `CHK("pin chip", 1'h1, chipRst)
    extRstN <= 1'h1;
    cyc(5);
    rdr(crg_pkg::OFS_WDSTAT);
    `CHK("wd clear", 32'h0, rd)
  endtask : t_resets
  initial
  begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'h0;
    // pin held low 1 ms (40000 cycles) after ideal supplies come up
    cyc(40000);
    extRstN <= 1'h1;
    cyc(4);
    t_regs();
    t_gate();
    t_switch();
    t_multi();
    t_resets();
    t_pll();
    conclude();
  end
endmodule : clock_reset_generation_unit_bench
bind crg_unit crg_unit_sva chk (.mclk(mclk), .sys_rst(sys_rst),
  .extRstN(extRstN), .wdogRst(wdogRst), .chipRst(chipRst),
  .resetVector(resetVector), .blkRst(blkRst), .funcClkTick(funcClkTick),
  .funcClkOn(funcClkOn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire
